// >>> shared/ldm_map.svh
// constants and field positions of the four-channel serial-bus led dimmer
// What this block does
// - low four address bits come from the four address select pins
// - data bytes load channel one to four brightness in order; all ones sinks for 255 of 256 clocks
// - each channel has 256 levels set by its 8-bit brightness value
// - any number of data bytes may follow between START and STOP
// - every byte is eight bits followed by one acknowledge slot
// - bytes travel most significant bit first
// - master clocks and releases the ack slot; receiver pulls data low to ack
// - data changes only while clock is low, stable while clock high
// - START is data falling while clock is high
// - STOP is data rising while clock is high
// - bus busy from START until STOP, free after STOP
// - a repeated START restarts address reception like a first START
// - clock and data inputs are glitch filtered before use
// - four independent pwm channels each drive one open-drain sink output
// - device runs from an internal oscillator and shows that clock divided by two on a pin
`ifndef LDM_MAP_SVH
`define LDM_MAP_SVH
`define LDM_ADDR_FIXED 4'h5
`define LDM_BYTE_BITS 4'h8
`define LDM_BIT_ZERO 4'h0
`define LDM_BIT_STEP 4'h1
`define LDM_CH_FIRST 2'h0
`define LDM_CH_STEP 2'h1
`define LDM_BRIGHT_RESET 32'h0000_0000
`define LDM_PWM_STEP 8'h01
`define LDM_PWM_RESET 8'h00
`define LDM_PIN_RESET 6'h3F
`define LDM_OE_OFF 4'hF
`define LDM_SINK_LEVEL 4'h0
`endif

// >>> shared/ldm_pkg.sv
// types shared by the led dimmer modules
package ldm_pkg;
    `include "ldm_map.svh"

    // bus receiver states
    typedef enum logic [2:0] {
        LDM_IDLE = 3'b000,
        LDM_ADDR = 3'b001,
        LDM_ACK_ADDR = 3'b010,
        LDM_DATA = 3'b011,
        LDM_ACK_DATA = 3'b100,
        LDM_IGNORE = 3'b101
    } ldm_state_t;

    typedef logic [3:0][7:0] ldm_bright_t;

    // complete state of the system-clock side
    typedef struct packed {
        logic scl_q;
        logic sda_q;
        ldm_state_t st;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic [1:0] idx;
        logic busy;
        logic sda_oe_n;
        ldm_bright_t bright;
        logic dirty;
        logic req_tgl;
        ldm_bright_t xdata;
        logic ack_s1;
        logic ack_s2;
        logic ack_s3;
        logic ack_seen;
    } ldm_top_st_t;

    // complete state of the oscillator side
    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_s3;
        logic ack_tgl;
        ldm_bright_t bright;
        logic [7:0] cnt;
        logic [3:0] oe_n;
        logic osc_tgl;
    } ldm_pwm_st_t;
endpackage

// >>> shared/ldm_xfer_if.sv
// brightness word crossing from the system clock to the oscillator clock
`timescale 1ns/1ps
`default_nettype none
interface ldm_xfer_if;
    logic req_tgl;
    logic [31:0] data;
    logic ack_tgl;
    modport src (output req_tgl, output data, input ack_tgl);
    modport dst (input req_tgl, input data, output ack_tgl);
endinterface
`default_nettype wire

// >>> rtl/ldm_pin_filter.sv
// three-stage glitch filter for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module ldm_pin_filter #(
    parameter int WIDTH = 6,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] pins_in,
    output logic [WIDTH-1:0] pins_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] out;
    } ldm_filt_st_t;

    ldm_filt_st_t s_r;
    ldm_filt_st_t s_nxt;

    // a bit moves only once stages two and three agree
    always_comb begin
        s_nxt = s_r;
        if (ce_in) begin
            s_nxt.s1 = pins_in;
            s_nxt.s2 = s_r.s1;
            s_nxt.s3 = s_r.s2;
            for (int i = 0; i < WIDTH; i++) begin
                if (s_r.s2[i] == s_r.s3[i]) begin
                    s_nxt.out[i] = s_r.s3[i];
                end
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pins_out = s_r.out;
endmodule // ldm_pin_filter
`default_nettype wire

// >>> rtl/ldm_pwm.sv
// four pwm channels and the clock pin on the oscillator clock
`timescale 1ns/1ps
`default_nettype none
`include "ldm_map.svh"
module ldm_pwm (
    input wire logic clk_osc_in,
    input wire logic rst_n_in,
    ldm_xfer_if.dst xif,
    output logic [3:0] sink_oe_n_out,
    output logic osc_clk_out
);
    import ldm_pkg::*;

    ldm_pwm_st_t s_r;
    ldm_pwm_st_t s_nxt;

    // a channel sinks while the period count is below its value
    function automatic logic sink_on(input logic [7:0] cnt, input logic [7:0] level);
        sink_on = (cnt < level);
    endfunction

    // take a new word once the request toggle has settled, then run pwm
    always_comb begin
        s_nxt = s_r;
        s_nxt.req_s1 = xif.req_tgl;
        s_nxt.req_s2 = s_r.req_s1;
        s_nxt.req_s3 = s_r.req_s2;
        if ((s_r.req_s2 == s_r.req_s3) && (s_r.req_s3 != s_r.ack_tgl)) begin
            s_nxt.bright = xif.data;
            s_nxt.ack_tgl = s_r.req_s3;
        end
        s_nxt.cnt = s_r.cnt + `LDM_PWM_STEP;
        for (int i = 0; i < 4; i++) begin
            s_nxt.oe_n[i] = !sink_on(s_r.cnt, s_r.bright[i]);
        end
        s_nxt.osc_tgl = !s_r.osc_tgl;
    end

    // state register
    always_ff @(posedge clk_osc_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= '{req_s1: 1'b0, req_s2: 1'b0, req_s3: 1'b0, ack_tgl: 1'b0,
                     bright: `LDM_BRIGHT_RESET, cnt: `LDM_PWM_RESET,
                     oe_n: `LDM_OE_OFF, osc_tgl: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign xif.ack_tgl = s_r.ack_tgl;
    assign sink_oe_n_out = s_r.oe_n;
    assign osc_clk_out = s_r.osc_tgl;

    // a dark channel never sinks
    chk_pwm_dark_off: assert property (@(posedge clk_osc_in) disable iff (!rst_n_in)
        (s_r.bright[0] == 8'h00) |=> s_r.oe_n[0])
        else $error("channel one sinks at zero brightness");

    // sink ends exactly when the count reaches the value; a value that changed mid-pulse is skipped
    chk_pwm_edge_pos: assert property (@(posedge clk_osc_in) disable iff (!rst_n_in)
        ($rose(s_r.oe_n[1]) && ($past(s_r.bright[1]) == $past(s_r.bright[1], 2)))
        |-> ($past(s_r.cnt) == $past(s_r.bright[1])))
        else $error("channel two pulse width wrong");
endmodule // ldm_pwm
`default_nettype wire

// >>> rtl/ldm_dimmer_top.sv
// serial bus target, brightness store and crossing for the led dimmer
`timescale 1ns/1ps
`default_nettype none
`include "ldm_map.svh"
module ldm_dimmer_top (
    input wire logic clk_sys_in,
    input wire logic clk_osc_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [3:0] addr_select_pins_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    output logic [3:0] channel_sink_outputs_out,
    output logic [3:0] channel_sink_outputs_oe_n_out,
    output logic osc_clk_out,
    output logic bus_busy_out
);
    import ldm_pkg::*;

    // ------------------------------------------------------------
    // pin filtering
    // ------------------------------------------------------------
    logic [5:0] pins_f;
    logic [3:0] addr_f;
    logic scl_f;
    logic sda_f;

    ldm_pin_filter #(
        .WIDTH(6),
        .RESET_VAL(`LDM_PIN_RESET)
    ) u_filter (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .pins_in({addr_select_pins_in, scl_in, sda_in}),
        .pins_out(pins_f)
    );

    // split the filtered pins
    assign addr_f = pins_f[5:2];
    assign scl_f = pins_f[1];
    assign sda_f = pins_f[0];

    // ------------------------------------------------------------
    // state and bus events
    // ------------------------------------------------------------
    ldm_top_st_t s_r;
    ldm_top_st_t s_nxt;
    ldm_xfer_if xif ();

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [7:0] own_addr;

    // byte complete once all eight bits are in
    function automatic logic byte_full(input logic [3:0] cnt);
        byte_full = (cnt == `LDM_BYTE_BITS);
    endfunction

    // edges of the filtered lines
    assign scl_rise = scl_f && !s_r.scl_q;
    assign scl_fall = !scl_f && s_r.scl_q;
    assign start_det = scl_f && s_r.scl_q && s_r.sda_q && !sda_f;
    assign stop_det = scl_f && s_r.scl_q && !s_r.sda_q && sda_f;
    assign own_addr = {`LDM_ADDR_FIXED, addr_f};

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        if (ce_in) begin
            s_nxt.scl_q = scl_f;
            s_nxt.sda_q = sda_f;
            // acknowledge toggle back from the oscillator side
            s_nxt.ack_s1 = xif.ack_tgl;
            s_nxt.ack_s2 = s_r.ack_s1;
            s_nxt.ack_s3 = s_r.ack_s2;
            if (s_r.ack_s2 == s_r.ack_s3) begin
                s_nxt.ack_seen = s_r.ack_s3;
            end
            // launch a new word when the last one is acknowledged
            if (s_r.dirty && (s_r.req_tgl == s_r.ack_seen)) begin
                s_nxt.xdata = s_r.bright;
                s_nxt.req_tgl = !s_r.req_tgl;
                s_nxt.dirty = 1'b0;
            end
            if (start_det) begin
                s_nxt.busy = 1'b1;
                s_nxt.st = LDM_ADDR;
                s_nxt.bitcnt = `LDM_BIT_ZERO;
                s_nxt.sda_oe_n = 1'b1;
            end else if (stop_det) begin
                s_nxt.busy = 1'b0;
                s_nxt.st = LDM_IDLE;
                s_nxt.sda_oe_n = 1'b1;
            end else begin
                case (s_r.st)
                    LDM_ADDR, LDM_DATA: begin
                        if (scl_rise && !byte_full(s_r.bitcnt)) begin
                            s_nxt.shift = {s_r.shift[6:0], sda_f};
                            s_nxt.bitcnt = s_r.bitcnt + `LDM_BIT_STEP;
                        end else if (scl_fall && byte_full(s_r.bitcnt)) begin
                            if (s_r.st == LDM_DATA) begin
                                s_nxt.bright[s_r.idx] = s_r.shift;
                                s_nxt.idx = s_r.idx + `LDM_CH_STEP;
                                s_nxt.dirty = 1'b1;
                                s_nxt.st = LDM_ACK_DATA;
                                s_nxt.sda_oe_n = 1'b0;
                            end else if (s_r.shift == own_addr) begin
                                s_nxt.idx = `LDM_CH_FIRST;
                                s_nxt.st = LDM_ACK_ADDR;
                                s_nxt.sda_oe_n = 1'b0;
                            end else begin
                                s_nxt.st = LDM_IGNORE;
                            end
                        end
                    end
                    LDM_ACK_ADDR, LDM_ACK_DATA: begin
                        if (scl_fall) begin
                            s_nxt.sda_oe_n = 1'b1;
                            s_nxt.st = LDM_DATA;
                            s_nxt.bitcnt = `LDM_BIT_ZERO;
                        end
                    end
                    LDM_IDLE, LDM_IGNORE: begin
                        s_nxt.sda_oe_n = 1'b1;
                    end
                    default: begin
                        s_nxt.st = LDM_IDLE;
                        s_nxt.sda_oe_n = 1'b1;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= '{scl_q: 1'b1, sda_q: 1'b1, st: LDM_IDLE, bitcnt: `LDM_BIT_ZERO,
                     shift: 8'h00, idx: `LDM_CH_FIRST, busy: 1'b0, sda_oe_n: 1'b1,
                     bright: `LDM_BRIGHT_RESET, dirty: 1'b0, req_tgl: 1'b0,
                     xdata: `LDM_BRIGHT_RESET, ack_s1: 1'b0, ack_s2: 1'b0,
                     ack_s3: 1'b0, ack_seen: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // crossing and pwm
    // ------------------------------------------------------------
    assign xif.req_tgl = s_r.req_tgl;
    assign xif.data = s_r.xdata;

    ldm_pwm u_pwm (
        .clk_osc_in(clk_osc_in),
        .rst_n_in(rst_n_in),
        .xif(xif),
        .sink_oe_n_out(channel_sink_outputs_oe_n_out),
        .osc_clk_out(osc_clk_out)
    );

    // open-drain pins only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe_n_out = s_r.sda_oe_n;
    assign channel_sink_outputs_out = `LDM_SINK_LEVEL;
    assign bus_busy_out = s_r.busy;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_start_busy: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (ce_in && start_det) |=> (bus_busy_out && (s_r.st == LDM_ADDR)))
        else $error("start did not mark the bus busy");

    chk_stop_free: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (ce_in && stop_det) |=> (!bus_busy_out && (s_r.st == LDM_IDLE) && sda_oe_n_out))
        else $error("stop did not free the bus");

    chk_restart_addr: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (ce_in && start_det && (s_r.st == LDM_DATA)) |=> (s_r.bitcnt == 4'h0) ##1 (s_r.st != LDM_DATA))
        else $error("repeated start did not restart address reception");

    chk_ack_drive: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ((s_r.st == LDM_ACK_ADDR) || (s_r.st == LDM_ACK_DATA)) |-> !sda_oe_n_out)
        else $error("acknowledge slot not driven low");

    chk_ignore_quiet: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (s_r.st == LDM_IGNORE) |-> sda_oe_n_out)
        else $error("foreign address acknowledged");

    chk_addr_match: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (ce_in && !start_det && !stop_det && scl_fall && (s_r.st == LDM_ADDR) && (s_r.bitcnt == 4'h8))
        |=> ((s_r.st == LDM_ACK_ADDR) == ($past(s_r.shift) == {4'h5, $past(addr_f)})))
        else $error("address decision wrong");

    chk_byte_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (ce_in && !start_det && !stop_det && scl_fall && (s_r.st == LDM_DATA) && (s_r.bitcnt == 4'h8))
        |=> ((s_r.bright[$past(s_r.idx)] == $past(s_r.shift)) && (s_r.idx == $past(s_r.idx) + 2'h1)))
        else $error("data byte not stored in the channel in turn");

    chk_ce_freeze: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !ce_in |=> ($stable(s_r.st) && $stable(s_r.bright)))
        else $error("state moved while clock enable low");
endmodule // ldm_dimmer_top
`default_nettype wire

// >>> tb/ldm_bus_master.sv
// serial bus master model that clocks address and brightness bytes into the dimmer
`timescale 1ns/1ps
`default_nettype none
module ldm_bus_master (
    input wire logic clk_sys_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    localparam int HALF = 10; // system clocks per bus clock phase, above the filter delay

    // both lines idle high
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    // wait n system clocks, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    // data falls while the clock is high, from idle or after an ack slot
    task automatic start_cond();
        sda_out = 1'b1;
        tick(HALF);
        scl_out = 1'b1;
        tick(HALF);
        sda_out = 1'b0;
        tick(HALF);
        scl_out = 1'b0;
        tick(HALF);
    endtask

    // data rises while the clock is high
    task automatic stop_cond();
        sda_out = 1'b0;
        tick(HALF);
        scl_out = 1'b1;
        tick(HALF);
        sda_out = 1'b1;
        tick(HALF);
    endtask

    // eight data bits then one ack slot; ack is high when the target pulled data low
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_out = b[i];
            tick(HALF);
            scl_out = 1'b1;
            tick(HALF);
            scl_out = 1'b0;
            tick(2);
        end
        sda_out = 1'b1;
        tick(HALF);
        scl_out = 1'b1;
        tick(HALF / 2);
        ack = ~sda_in;
        tick(HALF / 2);
        scl_out = 1'b0;
        tick(2);
    endtask

    // a data pulse far shorter than one system clock while the clock is high
    task automatic glitch();
        tick(1);
        sda_out = 1'b0;
        #10;
        sda_out = 1'b1;
    endtask
endmodule // ldm_bus_master
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the four-channel serial-bus led dimmer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys;
    logic clk_osc;
    logic rst_n;
    logic ce;
    logic [3:0] pins;
    wire logic scl;
    wire logic m_sda;
    wire logic sda_w;
    logic dev_sda;
    logic sda_oe_n;
    logic [3:0] sink;
    logic [3:0] sink_oe_n;
    logic osc_clk;
    logic busy;
    logic prev;
    logic [7:0] data_q [$];
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    // open-drain data line with pull-up: low when any party pulls it
    assign sda_w = m_sda & (sda_oe_n | dev_sda);

    ldm_dimmer_top i_ldm_dimmer_top (
        .clk_sys_in(clk_sys), .clk_osc_in(clk_osc), .rst_n_in(rst_n), .ce_in(ce),
        .addr_select_pins_in(pins), .scl_in(scl), .sda_in(sda_w), .sda_out(dev_sda),
        .sda_oe_n_out(sda_oe_n), .channel_sink_outputs_out(sink),
        .channel_sink_outputs_oe_n_out(sink_oe_n), .osc_clk_out(osc_clk), .bus_busy_out(busy)
    );

    ldm_bus_master i_ldm_bus_master (
        .clk_sys_in(clk_sys), .sda_in(sda_w), .scl_out(scl), .sda_out(m_sda)
    );

    // ---------------------------------------------------------------
    // clocks and hang guard
    // ---------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // oscillator clock, offset so the two never line up
    initial begin
        clk_osc = 1'b0;
        #3.7;
        forever #7.5 clk_osc = ~clk_osc;
    end

    // cut a hang short after far more cycles than the tests need
    initial begin
        forever begin
            @(posedge clk_sys);
            cycles++;
            if (cycles == 30000) begin
                err_count++;
                $display("Error timeout at %0t", $time);
                stop_test();
            end
        end
    end

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // start, address, the queued bytes, then stop unless a repeated start follows
    task automatic xfer(input logic [7:0] addr, input logic exp_ack, input logic do_stop);
        logic ack;
        i_ldm_bus_master.start_cond();
        check({8'h00, busy}, 9'h001);
        i_ldm_bus_master.send_byte(addr, ack);
        check({8'h00, ack}, {8'h00, exp_ack});
        foreach (data_q[k]) begin
            i_ldm_bus_master.send_byte(data_q[k], ack);
            check({8'h00, ack}, {8'h00, exp_ack});
        end
        if (do_stop) begin
            i_ldm_bus_master.stop_cond();
            check({8'h00, busy}, 9'h000);
            check({8'h00, sda_oe_n}, 9'h001);
        end
    endtask

    // count sink clocks of each channel over one full 256-clock period
    task automatic pwm_check(input logic [31:0] e);
        logic [8:0] cnt [4];
        cnt = '{default: 9'h000};
        repeat (40) @(posedge clk_osc);
        repeat (256) begin
            @(posedge clk_osc);
            #1;
            for (int c = 0; c < 4; c++) if (sink_oe_n[c] === 1'b0) cnt[c] += 9'h001;
        end
        for (int c = 0; c < 4; c++) check(cnt[c], {1'b0, e[c*8 +: 8]});
    endtask

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        pins = 4'hA;
        repeat (8) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        check({5'h00, sink_oe_n}, 9'h00F);
        check({8'h00, sda_oe_n}, 9'h001);
        check({8'h00, busy}, 9'h000);
        check({8'h00, dev_sda}, 9'h000);
        pwm_check(32'h0000_0000);
        $display("test reset done");
        data_q = '{8'h01, 8'hFF, 8'h80, 8'h00};
        xfer(8'h5A, 1'b1, 1'b1);
        pwm_check(32'h0080_FF01);
        check({5'h00, sink}, 9'h000);
        $display("test four channels done");
        data_q = '{8'h33};
        xfer(8'h5B, 1'b0, 1'b1);
        xfer(8'h4A, 1'b0, 1'b1);
        pwm_check(32'h0080_FF01);
        $display("test foreign address done");
        data_q = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
        xfer(8'h5A, 1'b1, 1'b1);
        pwm_check(32'h4433_2255);
        $display("test long transfer done");
        data_q = '{8'h66, 8'h77};
        xfer(8'h5A, 1'b1, 1'b0);
        data_q = '{8'h99};
        xfer(8'h5A, 1'b1, 1'b1);
        pwm_check(32'h4433_7799);
        $display("test repeated start done");
        i_ldm_bus_master.glitch();
        i_ldm_bus_master.tick(10);
        check({8'h00, busy}, 9'h000);
        $display("test glitch done");
        // with the clock enable low a START must leave the receiver untouched
        ce = 1'b0;
        i_ldm_bus_master.start_cond();
        check({8'h00, busy}, 9'h000);
        i_ldm_bus_master.stop_cond();
        ce = 1'b1;
        i_ldm_bus_master.tick(10);
        check({8'h00, busy}, 9'h000);
        $display("test clock enable done");
        @(posedge clk_osc);
        #1;
        prev = osc_clk;
        @(posedge clk_osc);
        #1;
        check({8'h00, osc_clk ^ prev}, 9'h001);
        $display("test clock pin done");
        stop_test();
    end
endmodule // testbench
`default_nettype wire
